// ==== src/swp_cond.v ====
`timescale 1ns/1ps
`default_nettype none
// Bus condition and clock edge detector
module swp_cond (
    input  wire core_clk,
    input  wire rst,
    input  wire scl_i,
    input  wire sda_i,
    output wire start_p,
    output wire stop_p,
    output wire rise_p,
    output wire fall_p
);
    reg scl_r;
    reg sda_r;

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            scl_r <= 1'b1;
            sda_r <= 1'b1;
        end else begin
            scl_r <= scl_i;
            sda_r <= sda_i;
        end
    end

    assign start_p = scl_r & scl_i & sda_r & ~sda_i;
    assign stop_p  = scl_r & scl_i & ~sda_r & sda_i;
    assign rise_p  = ~scl_r & scl_i;
    assign fall_p  = scl_r & ~scl_i;
endmodule // swp_cond
`default_nettype wire

// ==== src/swp_consts.vh ====
// How it works
// - Word address from master or counter
// - Power-up enters standby awaiting start
// - Latch clear at power-up blocks writes
// - Data line released at power-up
// - Reset output held for timeout
// - Writes happen only with latch set
// - Commit needs exact clocks before stop
// - Three-step unlock before config change
// - Protect pin high blocks every write
// - Early or mid-byte stop aborts write
// - No address acknowledge while writing
// - Read continues while master acknowledges
`ifndef SWP_CONSTS_VH
`define SWP_CONSTS_VH
`define SWP_CLK_MHZ    100
`define SWP_PURST_US   1000
`define SWP_TWC_US     5000
`define SWP_ID_MEM     4'b1010
`define SWP_ID_REG     4'b1011
`define SWP_REG_WORD   8'hFF
`define SWP_CR_WEL     1
`define SWP_CR_RWEL    2
`define SWP_CR_BL_LO   3
`define SWP_CR_WD_LO   5
`define SWP_CR_RST     8'h00
`define SWP_ADDR_RST   9'h000
`endif

// ==== src/swp_top.v ====
`timescale 1ns/1ps
`default_nettype none
`include "swp_consts.vh"
module swp_top #(
    parameter [23:0] PURST_CYC = `SWP_PURST_US * `SWP_CLK_MHZ,
    parameter [23:0] TWC_CYC   = `SWP_TWC_US * `SWP_CLK_MHZ
) (
    input  wire       core_clk,
    input  wire       rst,
    input  wire       scl_i,
    input  wire       sda_i,
    output reg        sda_o,
    output reg        sda_oe,
    input  wire       wp_i,
    input  wire [7:0] fault_bits,
    output reg        reset_out,
    output reg        write_enable_latch,
    output reg        nv_busy,
    output wire       standby,
    output wire [1:0] wd_sel,
    output wire [1:0] blk_lock
);
    localparam [3:0] ST_IDLE  = 4'h0;
    localparam [3:0] ST_DEV   = 4'h1;
    localparam [3:0] ST_DACK  = 4'h2;
    localparam [3:0] ST_WADR  = 4'h3;
    localparam [3:0] ST_WACK  = 4'h4;
    localparam [3:0] ST_WDAT  = 4'h5;
    localparam [3:0] ST_DWACK = 4'h6;
    localparam [3:0] ST_RDAT  = 4'h7;
    localparam [3:0] ST_RACK  = 4'h8;

    wire       start_p;
    wire       stop_p;
    wire       rise_p;
    wire       fall_p;
    reg  [3:0] state_r;
    reg  [3:0] cnt_r;
    reg  [7:0] sh_r;
    reg  [7:0] tx_r;
    reg        rd_r;
    reg        reg_tgt_r;
    reg        cr_sel_r;
    reg  [8:0] addr_r;
    reg  [8:0] paddr_r;
    reg  [7:0] pdat_r;
    reg        wr_ok_r;
    reg        mack_r;
    reg        unlock_r;
    reg  [7:0] cr_r;
    reg  [23:0] por_cnt_r;
    reg  [23:0] wc_cnt_r;
    reg  [7:0] mem_r [0:511];
    wire       commit;
    wire       mem_wr;
    wire [7:0] rd_now;

    swp_cond u_cond (
        .core_clk (core_clk),
        .rst      (rst),
        .scl_i    (scl_i),
        .sda_i    (sda_i),
        .start_p  (start_p),
        .stop_p   (stop_p),
        .rise_p   (rise_p),
        .fall_p   (fall_p)
    );

    // Byte the device presents for a read at the given address
    function [7:0] rd_byte;
        input       is_reg;
        input       is_cr;
        input [8:0] a;
        begin
            if (!is_reg)
                rd_byte = mem_r[a];
            else if (is_cr)
                rd_byte = cr_r;
            else
                rd_byte = fault_bits;
        end
    endfunction

    assign rd_now = rd_byte(reg_tgt_r, cr_sel_r, addr_r);
    // Stop right after a data acknowledge; its own clock rise counts one
    assign commit = stop_p && state_r == ST_WDAT && cnt_r == 4'h1 &&
                    wr_ok_r && !nv_busy && !wp_i;
    assign mem_wr = commit && !reg_tgt_r && write_enable_latch;
    assign standby = state_r == ST_IDLE && !nv_busy;
    assign wd_sel   = cr_r[`SWP_CR_WD_LO+1:`SWP_CR_WD_LO];
    assign blk_lock = cr_r[`SWP_CR_BL_LO+1:`SWP_CR_BL_LO];

    // Array is plain storage; no reset keeps it cheap
    always @(posedge core_clk) begin
        if (mem_wr)
            mem_r[paddr_r] <= pdat_r;
    end

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reset_out <= 1'b1;
            por_cnt_r <= 24'h00_0000;
        end else if (por_cnt_r >= PURST_CYC - 24'h00_0001) begin
            reset_out <= 1'b0;
        end else begin
            por_cnt_r <= por_cnt_r + 24'h00_0001;
        end
    end

    // Write latch, unlock sequence and control bits
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            write_enable_latch <= 1'b0;
            unlock_r <= 1'b0;
            cr_r     <= `SWP_CR_RST;
            nv_busy  <= 1'b0;
            wc_cnt_r <= 24'h00_0000;
        end else begin
            if (nv_busy) begin
                if (wc_cnt_r >= TWC_CYC - 24'h00_0001) begin
                    nv_busy  <= 1'b0;
                    wc_cnt_r <= 24'h00_0000;
                end else begin
                    wc_cnt_r <= wc_cnt_r + 24'h00_0001;
                end
            end
            if (mem_wr)
                nv_busy <= 1'b1;
            if (commit && reg_tgt_r && cr_sel_r) begin
                if (unlock_r && !pdat_r[`SWP_CR_RWEL]) begin
                    // Third step: settings finally land
                    cr_r     <= pdat_r;
                    write_enable_latch <= pdat_r[`SWP_CR_WEL];
                    unlock_r <= 1'b0;
                    nv_busy  <= 1'b1;
                end else if (pdat_r[`SWP_CR_RWEL] &&
                             pdat_r[`SWP_CR_WEL] &&
                             write_enable_latch) begin
                    unlock_r <= 1'b1;
                end else if (!pdat_r[`SWP_CR_RWEL]) begin
                    // Latch may change; settings stay put
                    write_enable_latch <= pdat_r[`SWP_CR_WEL];
                end
            end
        end
    end

    // Serial slave sequencer
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r   <= ST_IDLE;
            sda_oe    <= 1'b0;
            sda_o     <= 1'b1;
            cnt_r     <= 4'h0;
            sh_r      <= 8'h00;
            tx_r      <= 8'h00;
            rd_r      <= 1'b0;
            reg_tgt_r <= 1'b0;
            cr_sel_r  <= 1'b0;
            addr_r    <= `SWP_ADDR_RST;
            paddr_r   <= `SWP_ADDR_RST;
            pdat_r    <= 8'h00;
            wr_ok_r   <= 1'b0;
            mack_r    <= 1'b0;
        end else if (start_p) begin
            state_r <= ST_DEV;
            cnt_r   <= 4'h0;
            sda_oe  <= 1'b0;
            wr_ok_r <= 1'b0;
        end else if (stop_p) begin
            // Any stop returns to idle; partial bytes are dropped
            state_r <= ST_IDLE;
            sda_oe  <= 1'b0;
            wr_ok_r <= 1'b0;
        end else if (rise_p) begin
            case (state_r)
                ST_DEV, ST_WADR, ST_WDAT: begin
                    sh_r  <= {sh_r[6:0], sda_i};
                    cnt_r <= cnt_r + 4'h1;
                    if (state_r == ST_WDAT && cnt_r == 4'h1)
                        wr_ok_r <= 1'b0;
                end
                ST_RACK: mack_r <= ~sda_i;
                default: ;
            endcase
        end else if (fall_p) begin
            case (state_r)
                ST_DEV: begin
                    if (cnt_r == 4'h8) begin
                        if (!nv_busy && sh_r[3:2] == 2'b00 &&
                            (sh_r[7:4] == `SWP_ID_MEM ||
                             sh_r[7:4] == `SWP_ID_REG)) begin
                            sda_oe    <= 1'b1;
                            sda_o     <= 1'b0;
                            rd_r      <= sh_r[0];
                            reg_tgt_r <= sh_r[7:4] == `SWP_ID_REG;
                            cr_sel_r  <= sh_r[1];
                            if (sh_r[7:4] == `SWP_ID_MEM)
                                addr_r[8] <= sh_r[1];
                            state_r <= ST_DACK;
                        end else begin
                            state_r <= ST_IDLE;
                        end
                    end
                end
                ST_DACK: begin
                    cnt_r <= 4'h0;
                    if (rd_r) begin
                        // Read from the internal counter
                        tx_r    <= rd_now;
                        sda_o   <= rd_now[7];
                        state_r <= ST_RDAT;
                    end else begin
                        sda_oe  <= 1'b0;
                        state_r <= ST_WADR;
                    end
                end
                ST_WADR: begin
                    if (cnt_r == 4'h8) begin
                        if (!reg_tgt_r)
                            addr_r[7:0] <= sh_r;
                        if (reg_tgt_r && sh_r != `SWP_REG_WORD) begin
                            state_r <= ST_IDLE;
                        end else begin
                            sda_oe  <= 1'b1;
                            sda_o   <= 1'b0;
                            state_r <= ST_WACK;
                        end
                    end
                end
                ST_WACK, ST_DWACK: begin
                    sda_oe  <= 1'b0;
                    cnt_r   <= 4'h0;
                    state_r <= ST_WDAT;
                end
                ST_WDAT: begin
                    if (cnt_r == 4'h8) begin
                        sda_oe  <= 1'b1;
                        sda_o   <= 1'b0;
                        pdat_r  <= sh_r;
                        paddr_r <= addr_r;
                        wr_ok_r <= 1'b1;
                        if (!reg_tgt_r)
                            addr_r <= addr_r + 9'h001;
                        state_r <= ST_DWACK;
                    end
                end
                ST_RDAT: begin
                    if (cnt_r == 4'h7) begin
                        sda_oe  <= 1'b0;
                        if (!reg_tgt_r)
                            addr_r <= addr_r + 9'h001;
                        state_r <= ST_RACK;
                    end else begin
                        sda_o <= tx_r[3'h6 - cnt_r[2:0]];
                        cnt_r <= cnt_r + 4'h1;
                    end
                end
                ST_RACK: begin
                    cnt_r <= 4'h0;
                    if (mack_r) begin
                        tx_r    <= rd_now;
                        sda_o   <= rd_now[7];
                        sda_oe  <= 1'b1;
                        state_r <= ST_RDAT;
                    end else begin
                        state_r <= ST_IDLE;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule // swp_top
`default_nettype wire

// ==== verification/swp_mstr.sv ====
`timescale 1ns/1ps
`default_nettype none
// Bus master model; clock stands high between frames
module swp_mstr (
    input  wire logic core_clk,
    input  wire logic sda_i,
    output var logic  scl,
    output var logic  sda_m
);
    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    task automatic hc();
        repeat (4) @(posedge core_clk);
    endtask
    task automatic bit_io(input logic b, output logic r);
        sda_m <= b;
        hc();
        scl <= 1'b1;
        hc();
        r = sda_i;
        scl <= 1'b0;
        hc();
    endtask
    // Start when a is 1, stop when a is 0
    task automatic cond(input logic a);
        @(posedge core_clk);
        sda_m <= a;
        hc();
        scl <= 1'b1;
        hc();
        sda_m <= ~a;
        hc();
        scl <= ~a;
        hc();
    endtask
    // Read ends with mack 1, then a stop
    task automatic xfer(input logic [7:0] d, input logic mack,
                        output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(mack, ack);
    endtask
endmodule // swp_mstr
`default_nettype wire

// ==== verification/swp_props.sv ====
`timescale 1ns/1ps
`default_nettype none
module swp_props #(
    parameter [23:0] PURST_CYC = 24'h14,
    parameter [23:0] TWC_CYC   = 24'h32
) (
    input wire logic       core_clk,
    input wire logic       rst,
    input wire logic       scl_i,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe,
    input wire logic       wp_i,
    input wire logic [7:0] fault_bits,
    input wire logic       reset_out,
    input wire logic       write_enable_latch,
    input wire logic       nv_busy,
    input wire logic       standby,
    input wire logic [1:0] wd_sel,
    input wire logic [1:0] blk_lock
);
    logic [23:0] up_r;
    logic [23:0] bz_r;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Saturating, so it never wraps back into the hold window
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            up_r <= 24'h0;
            bz_r <= 24'h0;
        end else begin
            if (up_r <= PURST_CYC)
                up_r <= up_r + 24'h1;
            bz_r <= nv_busy ? bz_r + 24'h1 : 24'h0;
        end
    end
    a_por_hold: assert property (reset_out == (up_r < PURST_CYC))
        else $error("reset output timing wrong");
    a_por_state: assert property ($fell(rst) |->
        standby && !sda_oe && !write_enable_latch)
        else $error("power-up state wrong");
    a_commit_latch: assert property
        ($rose(nv_busy) |-> $past(write_enable_latch))
        else $error("write with latch clear");
    a_commit_wp: assert property ($rose(nv_busy) |-> !$past(wp_i))
        else $error("write while protected");
    a_commit_stop: assert property ($rose(nv_busy) |-> scl_i && sda_i)
        else $error("write not at stop");
    a_busy_quiet: assert property (nv_busy |-> !sda_oe)
        else $error("driving line while busy");
    a_busy_len: assert property ($fell(nv_busy) |->
        bz_r >= TWC_CYC - 24'h1 && bz_r <= TWC_CYC + 24'h1)
        else $error("busy length wrong");
    a_cfg_guard: assert property
        (!$stable({wd_sel, blk_lock}) |-> nv_busy)
        else $error("config changed without commit");
    a_drive_scl_low: assert property
        ($rose(sda_oe) |-> !scl_i && !$past(scl_i))
        else $error("drive began with clock high");
endmodule // swp_props
bind swp_top swp_props #(.PURST_CYC(PURST_CYC), .TWC_CYC(TWC_CYC))
    u_props (
        .core_clk           (core_clk),
        .rst                (rst),
        .scl_i              (scl_i),
        .sda_i              (sda_i),
        .sda_o              (sda_o),
        .sda_oe             (sda_oe),
        .wp_i               (wp_i),
        .fault_bits         (fault_bits),
        .reset_out          (reset_out),
        .write_enable_latch (write_enable_latch),
        .nv_busy            (nv_busy),
        .standby            (standby),
        .wd_sel             (wd_sel),
        .blk_lock           (blk_lock)
    );
`default_nettype wire

// ==== verification/swp_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module serial_write_protect_powerup_tb_top;
    logic       core_clk, rst, wp_i, scl, sda_m, sda_o, sda_oe, ack;
    logic       reset_out, write_enable_latch, nv_busy, standby;
    logic [7:0] fault_bits, q;
    logic [1:0] wd_sel, blk_lock;
    wire        sda_i;
    int         num_errors = 0;
    int         samples_checked = 0;
    // Pull-up line; a driven 1 counts as released
    assign sda_i = sda_m & ~(sda_oe & ~sda_o);
    swp_top #(.PURST_CYC(24'h14), .TWC_CYC(24'h12C)) DUT (
        .core_clk(core_clk), .rst(rst), .scl_i(scl), .sda_i(sda_i),
        .sda_o(sda_o), .sda_oe(sda_oe), .wp_i(wp_i), .fault_bits(fault_bits),
        .reset_out(reset_out), .write_enable_latch(write_enable_latch),
        .nv_busy(nv_busy), .standby(standby), .wd_sel(wd_sel),
        .blk_lock(blk_lock));
    swp_mstr M (.core_clk(core_clk), .sda_i(sda_i), .scl(scl), .sda_m(sda_m));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] dev, wa, d);
        M.cond(1'b1);
        M.xfer(dev, 1'b1, q, ack);
        M.xfer(wa, 1'b1, q, ack);
        M.xfer(d, 1'b1, q, ack);
        M.cond(1'b0);
        #1;
        chk(ack, 8'h0);
    endtask
    task automatic rd2(input logic [7:0] dev, wa, e0, e1);
        M.cond(1'b1);
        M.xfer(dev, 1'b1, q, ack);
        M.xfer(wa, 1'b1, q, ack);
        M.cond(1'b1);
        M.xfer(dev | 8'h01, 1'b1, q, ack);
        M.xfer(8'hFF, 1'b0, q, ack);
        chk(q, e0);
        M.xfer(8'hFF, 1'b1, q, ack);
        chk(q, e1);
        M.cond(1'b0);
    endtask
    task automatic idle();
        for (int i = 0; i < 400 && nv_busy; i++)
            @(posedge core_clk);
        #1;
        chk(nv_busy, 8'h0);
    endtask
    initial begin
        rst = 1'b1;
        wp_i = 1'b0;
        fault_bits = 8'h3C;
        repeat (2) @(posedge core_clk);
        #1;
        chk({standby, reset_out, write_enable_latch, sda_oe}, 8'h0C);
        @(posedge core_clk);
        rst <= 1'b0;
        repeat (18) @(posedge core_clk);
        #1;
        chk(reset_out, 8'h1);
        repeat (3) @(posedge core_clk);
        #1;
        chk(reset_out, 8'h0);
        wr(8'hA0, 8'h10, 8'h11);
        chk(nv_busy, 8'h0);
        wr(8'hB2, 8'hFF, 8'h02);
        chk({write_enable_latch, nv_busy}, 8'h2);
        @(posedge core_clk);
        wp_i <= 1'b1;
        wr(8'hA0, 8'h10, 8'h11);
        chk(nv_busy, 8'h0);
        @(posedge core_clk);
        wp_i <= 1'b0;
        M.cond(1'b1);
        M.xfer(8'hA0, 1'b1, q, ack);
        M.xfer(8'h10, 1'b1, q, ack);
        M.cond(1'b0);
        #1;
        chk(nv_busy, 8'h0);
        wr(8'hA0, 8'h11, 8'h5A);
        chk(nv_busy, 8'h1);
        M.cond(1'b1);
        M.xfer(8'hA0, 1'b1, q, ack);
        chk(ack, 8'h1);
        M.cond(1'b0);
        idle();
        wr(8'hA0, 8'h10, 8'hA5);
        idle();
        rd2(8'hA0, 8'h10, 8'hA5, 8'h5A);
        rd2(8'hB0, 8'hFF, 8'h3C, 8'h3C);
        fault_bits <= 8'hA6;
        rd2(8'hB0, 8'hFF, 8'hA6, 8'hA6);
        wr(8'hB2, 8'hFF, 8'h78);
        chk({wd_sel, blk_lock}, 8'h0);
        idle();
        wr(8'hB2, 8'hFF, 8'h02);
        wr(8'hB2, 8'hFF, 8'h06);
        wr(8'hB2, 8'hFF, 8'h78);
        chk({wd_sel, blk_lock, write_enable_latch}, 8'h1E);
        idle();
        chk(standby, 8'h1);
        print_verdict();
    end
    // Run needs about 60 us; this leaves ample margin
    initial begin
        #200000;
        num_errors++;
        print_verdict();
    end
endmodule // serial_write_protect_powerup_tb_top
`default_nettype wire
